// ---- hw/flag_cell.sv ----
// one sticky factor flag with write-one-to-clear and gated request
`default_nettype none
module flag_cell
  import irq_bank_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cause,
  input wire logic clear,
  input wire logic enable,
  output logic flag_r,
  output logic request
);
  // set wins over a clear in the same cycle so no cause is lost
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      flag_r <= 1'b0; // RULE4
    end
    else if (cause)
    begin
      flag_r <= 1'b1; // RULE18
    end
    else if (clear)
    begin
      flag_r <= 1'b0; // RULE5
    end

  // level request holds until software clears the flag or its enable
  assign request = flag_r & enable; // RULE18 RULE12

  a_flag_sets: assert property (@(posedge clk) disable iff (!rst_b)
    cause |=> flag_r) // RULE18
    else $error("flag did not set after cause");
  a_flag_clears: assert property (@(posedge clk) disable iff (!rst_b)
    clear && !cause |=> !flag_r) // RULE5
    else $error("flag did not clear on write one");
  a_flag_holds: assert property (@(posedge clk) disable iff (!rst_b)
    flag_r && !clear |=> flag_r) // RULE12
    else $error("flag dropped without clear");
endmodule // flag_cell
`default_nettype wire

// ---- hw/irq_bank_pkg.sv ----
// constants and register map of the interrupt enable and factor flag bank
// What this block does
// RULE1 - enable bits gate their source, read/write, clear to zero at reset
// RULE2 - main enable: timer1, timer0, key pair, keys4-7, keys0-3, serial err/rx/tx
// RULE3 - time-base enable bits 3..0: clock timer 32, 8, 2, 1 Hz
// RULE4 - factor flag reads one once its cause occurred; zero after reset
// RULE5 - writing one clears a factor flag, writing zero leaves it
// RULE6 - time-base flags: stopwatch 100/10/1 Hz at 6..4, clock timer 3..0, bit7 zero
// RULE7 - main flag register uses the same bit order as main enable
// RULE8 - aux enable: timer3 bit7, timer2 bit6, carrier bit5, bits 3..0 read zero
// RULE9 - aux flags: timer3 bit7, timer2 bit6, carrier bit5, bits 3..0 read zero
// RULE10 - aux enable bit4 switches carrier generation, one after reset
// RULE11 - aux flag bit4 forces remote output, read/write, zero after reset
// RULE12 - a flag still set after handler return requests again
// RULE13 - software clears the flag before lowering the cpu mask
// RULE14 - software waits 2 msec after watchdog interrupt before sleeping
// RULE15 - shared handlers start inside the common area
// RULE16 - two-bit priority per system, 11 level3 .. 00 never, zero after reset
// RULE17 - accept only levels above the cpu mask; watchdog level 4 always
// RULE18 - request while flag and enable both one; cause sets flag regardless
`default_nettype none
package irq_bank_pkg;
  localparam logic [23:0] ADDR_PRIO_A = 24'h00ff20;
  localparam logic [23:0] ADDR_PRIO_B = 24'h00ff21;
  localparam logic [23:0] ADDR_EN_TB = 24'h00ff22;
  localparam logic [23:0] ADDR_EN_MAIN = 24'h00ff23;
  localparam logic [23:0] ADDR_FLAG_TB = 24'h00ff24;
  localparam logic [23:0] ADDR_FLAG_MAIN = 24'h00ff25;
  localparam logic [23:0] ADDR_EN_AUX = 24'h00ff26;
  localparam logic [23:0] ADDR_FLAG_AUX = 24'h00ff27;
  localparam logic [23:0] ADDR_IRQ_STAT = 24'h00ff28;
  localparam logic [23:0] ADDR_IRQ_MASK = 24'h00ff29;
  // implemented bit masks of the time-base, aux and status registers
  localparam logic [7:0] MASK_EN_TB = 8'h0f;
  localparam logic [7:0] MASK_FLAG_TB = 8'h7f;
  localparam logic [7:0] MASK_AUX_IRQ = 8'he0;
  localparam logic [7:0] MASK_STAT = 8'h07;
  // bit positions in the aux registers
  localparam int BIT_CARRIER_GEN = 4;
  localparam int BIT_FORCED_OUT = 4;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_EN_AUX = 8'h10;
  // request lines: main 8, time-base 7, aux 3
  localparam int NUM_SRC = 18;
  // cpu level codes
  localparam logic [2:0] LVL_NMI = 3'h4;
endpackage
`default_nettype wire

// ---- hw/irq_enable_flag_bank.sv ----
// interrupt enable, factor flag, priority and carrier control register bank
`default_nettype none
module irq_enable_flag_bank
  import irq_bank_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [23:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] main_cause,
  input wire logic [6:0] timebase_cause,
  input wire logic [2:0] aux_cause,
  input wire logic nmi_req,
  input wire logic cpu_mask_bit_hi,
  input wire logic cpu_mask_bit_lo,
  output logic [NUM_SRC-1:0] src_request,
  output logic [2:0] irq_level,
  output logic irq_accept,
  output logic carrier_gen_on,
  output logic carrier_forced_out,
  output logic bank_irq
);
  logic [7:0] en_main_r;
  logic [3:0] en_tb_r;
  logic [2:0] en_aux_r;
  logic gen_on_r;
  logic forced_r;
  logic [7:0] prio_a_r;
  logic [7:0] prio_b_r;
  logic [2:0] stat_r;
  logic [2:0] stat_mask_r;
  logic [NUM_SRC-1:0] cause_all;
  logic [NUM_SRC-1:0] clear_all;
  logic [NUM_SRC-1:0] en_all;
  logic [NUM_SRC-1:0] flag_all;
  logic [7:0] rdata_nxt;
  logic [7:0] sys_req;
  logic wr_flag_main;
  logic wr_flag_tb;
  logic wr_flag_aux;

  assign wr_flag_main = reg_wr && reg_addr == ADDR_FLAG_MAIN;
  assign wr_flag_tb = reg_wr && reg_addr == ADDR_FLAG_TB;
  assign wr_flag_aux = reg_wr && reg_addr == ADDR_FLAG_AUX;

  // enable registers, all zero after reset except carrier generation
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      en_main_r <= RST_ZERO; // RULE1
      en_tb_r <= 4'h0;
      en_aux_r <= 3'h0;
      gen_on_r <= RST_EN_AUX[BIT_CARRIER_GEN]; // RULE10
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_EN_MAIN)
      begin
        en_main_r <= reg_wdata; // RULE2
      end
      if (reg_addr == ADDR_EN_TB)
      begin
        en_tb_r <= reg_wdata[3:0]; // RULE3
      end
      if (reg_addr == ADDR_EN_AUX)
      begin
        en_aux_r <= reg_wdata[7:5]; // RULE8
        gen_on_r <= reg_wdata[BIT_CARRIER_GEN]; // RULE10
      end
    end

  // forced output bit is plain storage beside the aux flags
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      forced_r <= 1'b0; // RULE11
    end
    else if (wr_flag_aux)
    begin
      forced_r <= reg_wdata[BIT_FORCED_OUT]; // RULE11
    end

  // priority fields, two bits per system
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      prio_a_r <= RST_ZERO; // RULE16
      prio_b_r <= RST_ZERO;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_PRIO_A)
      begin
        prio_a_r <= reg_wdata;
      end
      if (reg_addr == ADDR_PRIO_B)
      begin
        prio_b_r <= reg_wdata;
      end
    end

  // flag vector order: main 7..0, then time-base 6..0, then aux 7..5
  assign cause_all = {main_cause, timebase_cause, aux_cause};
  assign clear_all = {{8{wr_flag_main}} & reg_wdata, // RULE5
    {7{wr_flag_tb}} & reg_wdata[6:0], {3{wr_flag_aux}} & reg_wdata[7:5]};
  assign en_all = {en_main_r, 3'h0, en_tb_r, en_aux_r}; // RULE7

  // stopwatch flags have no enable in this bank, so they never request
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_flag
      flag_cell u_cell (
        .clk(clk),
        .rst_b(rst_b),
        .cause(cause_all[g]),
        .clear(clear_all[g]),
        .enable(en_all[g]),
        .flag_r(flag_all[g]),
        .request(src_request[g])
      );
    end
  endgenerate

  // collapse per-source requests into the eight priority systems
  assign sys_req[0] = |src_request[6:3]; // clock timer
  assign sys_req[1] = |src_request[9:7]; // stopwatch
  assign sys_req[2] = |src_request[12:10]; // serial
  assign sys_req[3] = |src_request[14:13]; // keys 0-7
  assign sys_req[4] = src_request[15]; // key pair
  assign sys_req[5] = |src_request[17:16]; // timers 0-1
  assign sys_req[6] = |src_request[2:1]; // timers 2-3
  assign sys_req[7] = src_request[0]; // carrier

  prio_select #(.NSYS(8)) u_prio (
    .sys_req(sys_req),
    .sys_prio({prio_b_r[7:6], prio_b_r[5:4], prio_b_r[3:2], prio_b_r[1:0],
      prio_a_r[7:6], prio_a_r[5:4], prio_a_r[3:2], prio_a_r[1:0]}),
    .cpu_mask_bit_hi(cpu_mask_bit_hi),
    .cpu_mask_bit_lo(cpu_mask_bit_lo),
    .nmi_req(nmi_req),
    .irq_level(irq_level),
    .irq_accept(irq_accept)
  );

  // summary status: any main, time-base or aux flag set; sticky, write one clears
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      stat_r <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (i == 0 ? |flag_all[17:10] : i == 1 ? |flag_all[9:3] : |flag_all[2:0])
        begin
          stat_r[i] <= 1'b1;
        end
        else if (reg_wr && reg_addr == ADDR_IRQ_STAT && reg_wdata[i])
        begin
          stat_r[i] <= 1'b0;
        end
      end
    end

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      stat_mask_r <= 3'h0;
    end
    else if (reg_wr && reg_addr == ADDR_IRQ_MASK)
    begin
      stat_mask_r <= reg_wdata[2:0];
    end

  assign bank_irq = |(stat_r & stat_mask_r);
  assign carrier_gen_on = gen_on_r;
  assign carrier_forced_out = forced_r;

  // read mux; unmapped addresses and reserved bits read zero
  always_comb
  begin
    unique case (reg_addr)
      ADDR_PRIO_A: rdata_nxt = prio_a_r;
      ADDR_PRIO_B: rdata_nxt = prio_b_r;
      ADDR_EN_TB: rdata_nxt = {4'h0, en_tb_r}; // RULE3
      ADDR_EN_MAIN: rdata_nxt = en_main_r; // RULE1
      ADDR_FLAG_TB: rdata_nxt = {1'b0, flag_all[9:3]}; // RULE6
      ADDR_FLAG_MAIN: rdata_nxt = flag_all[17:10]; // RULE7 RULE4
      ADDR_EN_AUX: rdata_nxt = {en_aux_r, gen_on_r, 4'h0}; // RULE8
      ADDR_FLAG_AUX: rdata_nxt = {flag_all[2:0], forced_r, 4'h0}; // RULE9
      ADDR_IRQ_STAT: rdata_nxt = {5'h0, stat_r};
      ADDR_IRQ_MASK: rdata_nxt = {5'h0, stat_mask_r};
      default: rdata_nxt = RST_ZERO;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      reg_rdata <= RST_ZERO;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_nxt;
    end
    else
    begin
      reg_rdata <= RST_ZERO;
    end

  a_aux_low_zero: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && (reg_addr == ADDR_EN_AUX || reg_addr == ADDR_FLAG_AUX)
    |=> reg_rdata[3:0] == 4'h0) // RULE8
    else $error("aux low bits not zero");
  a_tb_bit7_zero: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == ADDR_FLAG_TB |=> !reg_rdata[7]) // RULE6
    else $error("time-base flag bit 7 not zero");
  a_main_en_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == ADDR_EN_MAIN ##1 reg_rd && reg_addr == ADDR_EN_MAIN
    |=> reg_rdata == $past(reg_wdata, 2)) // RULE1 RULE2
    else $error("main enable readback mismatch");
  a_carrier_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == ADDR_EN_AUX |=> carrier_gen_on == $past(reg_wdata[4])) // RULE10
    else $error("carrier generation bit not updated");
  a_forced_write: assert property (@(posedge clk) disable iff (!rst_b)
    wr_flag_aux |=> carrier_forced_out == $past(reg_wdata[4])) // RULE11
    else $error("forced output bit not updated");
  a_request_gate: assert property (@(posedge clk) disable iff (!rst_b)
    src_request[17] == (flag_all[17] && en_main_r[7])) // RULE18
    else $error("timer 1 request not flag and enable");
  a_nmi_always: assert property (@(posedge clk) disable iff (!rst_b)
    nmi_req |-> irq_accept && irq_level == LVL_NMI) // RULE17
    else $error("watchdog not accepted");
  a_mask_block: assert property (@(posedge clk) disable iff (!rst_b)
    !nmi_req && cpu_mask_bit_hi && cpu_mask_bit_lo |-> !irq_accept) // RULE17
    else $error("request accepted through full mask");

  c_flag_clear: cover property (@(posedge clk) wr_flag_main && |flag_all[17:10]);
  c_accept: cover property (@(posedge clk) irq_accept && !nmi_req);
  c_bank_irq: cover property (@(posedge clk) bank_irq);
endmodule // irq_enable_flag_bank
`default_nettype wire

// ---- hw/prio_select.sv ----
// picks the highest requested priority level from per-system requests and tests it against the cpu mask
`default_nettype none
module prio_select
  import irq_bank_pkg::*;
#(
  parameter int NSYS = 8
)
(
  input wire logic [NSYS-1:0] sys_req,
  input wire logic [2*NSYS-1:0] sys_prio,
  input wire logic cpu_mask_bit_hi,
  input wire logic cpu_mask_bit_lo,
  input wire logic nmi_req,
  output logic [2:0] irq_level,
  output logic irq_accept
);
  logic [1:0] best;
  always_comb
  begin
    best = 2'h0;
    for (int i = 0; i < NSYS; i++)
    begin
      // level 00 is never raised
      if (sys_req[i] && sys_prio[2*i +: 2] > best)
      begin
        best = sys_prio[2*i +: 2]; // RULE16
      end
    end
  end

  // watchdog always wins; others must exceed the cpu mask level
  always_comb
  begin
    if (nmi_req)
    begin
      irq_level = LVL_NMI; // RULE17
      irq_accept = 1'b1;
    end
    else
    begin
      irq_level = {1'b0, best};
      irq_accept = best > {cpu_mask_bit_hi, cpu_mask_bit_lo}; // RULE17 RULE13
    end
  end
endmodule // prio_select
`default_nettype wire

// ---- testbench/cpu_model.sv ----
// behavioural cpu core side: interrupt mask flags and acceptance
`default_nettype none
module cpu_model
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic irq_accept,
  input wire logic [2:0] irq_level,
  input wire logic ret,
  output logic cpu_mask_bit_hi,
  output logic cpu_mask_bit_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mask_r;
  assign cpu_mask_bit_hi = mask_r[1];
  assign cpu_mask_bit_lo = mask_r[0];
  // the model never sleeps after a watchdog request and has no banks
  // mask rises to the accepted level, or to 3 for the watchdog level 4; return restores the idle mask of zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      mask_r <= 2'h0;
    else if (irq_accept)
      mask_r <= (irq_level == 3'h4) ? 2'h3 : irq_level[1:0];
    else if (ret)
      mask_r <= 2'h0;
  end
endmodule // cpu_model
`default_nettype wire

// ---- testbench/irq_enable_flag_bank_tb.sv ----
// self-checking bench for the interrupt enable and factor flag bank
`default_nettype none
module irq_enable_flag_bank_tb import irq_bank_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, nmi_req = 1'b0, ret = 1'b0;
  logic [23:0] reg_addr = 24'h0;
  logic [7:0] reg_wdata = 8'h0, main_cause = 8'h0, reg_rdata;
  logic [6:0] timebase_cause = 7'h0;
  logic [2:0] aux_cause = 3'h0, irq_level;
  logic hi, lo, irq_accept, carrier_gen_on, carrier_forced_out, bank_irq;
  logic [NUM_SRC-1:0] src_request;
  int fails = 0, num_checks = 0;
  irq_enable_flag_bank dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .main_cause(main_cause), .timebase_cause(timebase_cause), .aux_cause(aux_cause),
    .nmi_req(nmi_req), .cpu_mask_bit_hi(hi), .cpu_mask_bit_lo(lo),
    .src_request(src_request), .irq_level(irq_level), .irq_accept(irq_accept),
    .carrier_gen_on(carrier_gen_on), .carrier_forced_out(carrier_forced_out),
    .bank_irq(bank_irq));
  cpu_model cpu_u (.clk(clk), .rst_b(rst_b), .irq_accept(irq_accept),
    .irq_level(irq_level), .ret(ret), .cpu_mask_bit_hi(hi), .cpu_mask_bit_lo(lo));
  // 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // write then read with no gap, the tightest spacing the bus allows
  task automatic wr_rd(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, d);
  endtask
  // read data stands only in the cycle after the read edge, so look there
  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic cause(input logic [7:0] m, input logic [6:0] t, input logic [2:0] x);
    @(posedge clk);
    main_cause <= m;
    timebase_cause <= t;
    aux_cause <= x;
    @(posedge clk);
    main_cause <= 8'h0;
    timebase_cause <= 7'h0;
    aux_cause <= 3'h0;
    #1;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 10; i++)
      rd(24'(24'h00ff20 + i), (i == 6) ? 8'h10 : 8'h00);
    chk(carrier_gen_on, 1'b1);
    chk(carrier_forced_out, 1'b0);
    chk(src_request, 18'h0);
    $display("reset values done");
  endtask
  // each main cause alone, then a write with its own bit zero that must not clear it
  task automatic t_main;
    wr_rd(ADDR_EN_MAIN, 8'h5a);
    wr(ADDR_EN_MAIN, 8'ha5);
    rd(ADDR_EN_MAIN, 8'ha5);
    for (int b = 0; b < 8; b++)
    begin
      cause(8'h1 << b, 7'h0, 3'h0);
      rd(ADDR_FLAG_MAIN, 8'h1 << b);
      chk(src_request[17:10], (8'h1 << b) & 8'ha5);
      wr(ADDR_FLAG_MAIN, ~(8'h1 << b));
      rd(ADDR_FLAG_MAIN, 8'h1 << b);
      wr(ADDR_FLAG_MAIN, 8'h1 << b);
      rd(ADDR_FLAG_MAIN, 8'h00);
    end
    $display("main flags done");
  endtask
  task automatic t_timebase;
    wr(ADDR_EN_TB, 8'hff);
    rd(ADDR_EN_TB, 8'h0f);
    cause(8'h0, 7'h7f, 3'h0);
    rd(ADDR_FLAG_TB, 8'h7f);
    chk(src_request[9:3], 7'h0f);
    wr(ADDR_FLAG_TB, 8'hff);
    rd(ADDR_FLAG_TB, 8'h00);
    $display("time-base flags done");
  endtask
  task automatic t_aux;
    wr(ADDR_EN_AUX, 8'hff);
    rd(ADDR_EN_AUX, 8'hf0);
    wr(ADDR_EN_AUX, 8'hef);
    chk(carrier_gen_on, 1'b0);
    cause(8'h0, 7'h0, 3'h7);
    wr(ADDR_FLAG_AUX, 8'h1f);
    rd(ADDR_FLAG_AUX, 8'hf0);
    chk(carrier_forced_out, 1'b1);
    chk(src_request[2:0], 3'h7);
    $display("aux registers done");
  endtask
  // sticky summary: main bit clears, time-base and aux bits stay
  task automatic t_summary;
    chk(bank_irq, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h01);
    chk(bank_irq, 1'b1);
    wr(ADDR_IRQ_STAT, 8'h01);
    chk(bank_irq, 1'b0);
    rd(ADDR_IRQ_STAT, 8'h06);
    rd(24'h00ff30, 8'h00);
    $display("summary interrupt done");
  endtask
  // carrier request at each level; return with its flag still set
  task automatic t_prio;
    for (int p = 0; p < 4; p++)
    begin
      wr(ADDR_PRIO_B, 8'(p << 6));
      chk(irq_level, 3'(p));
      chk(irq_accept, p != 0);
      @(posedge clk);
      #1 chk(irq_accept, 1'b0);
      @(posedge clk);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      #1 chk(irq_accept, p != 0);
    end
    @(posedge clk);
    nmi_req <= 1'b1;
    @(posedge clk);
    #1 chk({irq_level, irq_accept}, 4'h9);
    @(posedge clk);
    nmi_req <= 1'b0;
    $display("priority and mask done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog sized well above the roughly 180 cycles the tests need
  initial
  begin
    #200000;
    fails++;
    stop_test();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_main();
    t_timebase();
    t_aux();
    t_summary();
    t_prio();
    stop_test();
  end
endmodule // irq_enable_flag_bank_tb
`default_nettype wire
